// ==== core/iar_router.sv ====
/*
 * Interrupt router: source steering onto 120 inputs, per-input settings,
 * priority arbitration and delivery as memory writes with requester id.
 * Assumes internal sources and the stream decoder share clk; only the
 * line A pin is asynchronous. The write sink holds ready as it likes.
 * An edge that arrives while its input is masked is lost; a level that
 * drops while its write waits is still delivered.
 */
`timescale 1ns/1ps
module iar_router
  import iar_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Mode
  input  wire logic                 advanced_mode,
  input  wire logic                 high_precision_event_timer_legacy_en,
  // Fixed legacy sources
  input  wire logic                 legacy_cascade,
  input  wire logic                 timer_counter0,
  input  wire logic                 high_precision_event_timer_0,
  input  wire logic                 rtc_irq,
  input  wire logic                 high_precision_event_timer_1,
  // Serial stream decoder outputs
  input  wire logic [N_LEGACY-1:0]  serial_interrupt_stream_irq,
  input  wire logic [3:0]           serial_interrupt_stream_line_b,
  // Shared lines
  input  wire logic                 shared_line_a_request_b,
  input  wire logic [3:0]           shared_lines_e_to_h_request_b,
  // Express legacy interrupt messages
  input  wire logic                 intx_msg_valid,
  input  wire logic                 intx_msg_assert,
  input  wire logic [1:0]           intx_msg_line,
  // Internal module sources
  input  wire logic [N_IRQ-1:0]     internal_irq,
  // Entry programming
  input  wire logic                 ent_wr,
  input  wire logic [IDX_W-1:0]     ent_idx,
  input  wire logic [VEC_W-1:0]     ent_vector,
  input  wire logic [PRIO_W-1:0]    ent_prio,
  input  wire logic                 ent_level,
  input  wire logic                 ent_active_low,
  input  wire logic                 ent_mask,
  // Configuration register access
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [RID_W-1:0]     cfg_wdata,
  output logic      [RID_W-1:0]     cfg_rdata,
  // Interrupt memory write
  output logic                      wr_valid,
  input  wire logic                 wr_ready,
  output logic      [VEC_W-1:0]     wr_vector,
  output logic      [RID_W-1:0]     wr_requester_id,
  // End of interrupt
  input  wire logic                 eoi_valid,
  input  wire logic [VEC_W-1:0]     eoi_vector,
  output logic                      eoi_pcie_fwd,
  output logic      [VEC_W-1:0]     eoi_pcie_vector
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [N_IRQ-1:0][VEC_W-1:0]  vec;
    logic [N_IRQ-1:0][PRIO_W-1:0] prio;
    logic [N_IRQ-1:0]             lvl;
    logic [N_IRQ-1:0]             pol;
    logic [N_IRQ-1:0]             msk;
    logic [RID_W-1:0]             rid;
    logic [3:0]                   intx;
    logic                         pin_s1;
    logic                         pin_s2;
    logic                         pin_s3;
    logic                         pin_lvl;
    iar_state_t                   st;
    logic [IDX_W-1:0]             idx;
    logic [VEC_W-1:0]             out_vec;
    logic [RID_W-1:0]             out_rid;
    logic                         fwd;
    logic [VEC_W-1:0]             fwd_vec;
    logic [RID_W-1:0]             rdata;
  } iar_router_t;

  iar_router_t r_ff;
  iar_router_t nxt_r;

  logic [N_IRQ-1:0] src;
  logic [N_IRQ-1:0] req;
  logic [N_IRQ-1:0] sent;
  logic [N_IRQ-1:0] eoi_hit;
  logic [3:0]       line_on;
  logic             win_any;
  logic [IDX_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_prio;
  logic             accept;
  logic             pin_active;
  logic [RID_W-1:0] stat_word;

  // ****************************************
  // Shared line decode
  // ****************************************
  // Synchronised line A pin, active low
  assign pin_active = !r_ff.pin_lvl;

  always_comb begin
    // R13: message latched lines A to D
    // R07: line A from stream, pin or message
    line_on[0] = !serial_interrupt_stream_line_b[0] || pin_active || r_ff.intx[0];
    for (int k = 1; k < 4; k++) begin
      line_on[k] = !serial_interrupt_stream_line_b[k] || r_ff.intx[k];
    end
  end

  // ****************************************
  // Source steering
  // ****************************************
  always_comb begin
    src = internal_irq;
    // Legacy inputs other than 0, 2, 8 and 13 share the stream decoder
    for (int i = 0; i < N_LEGACY; i++) begin
      src[i] = internal_irq[i] | serial_interrupt_stream_irq[i];
    end
    // R04: cascade only
    src[IRQ_CASCADE] = legacy_cascade;
    // R05: interval timer or event timer 0
    src[IRQ_TIMER] = high_precision_event_timer_legacy_en ? high_precision_event_timer_0
                                                          : timer_counter0;
    // R06: clock or event timer 1
    src[IRQ_RTC] = high_precision_event_timer_legacy_en ? high_precision_event_timer_1
                                                        : rtc_irq;
    src[IRQ_RSVD] = internal_irq[IRQ_RSVD];
    // R10: lines A to H onto 16 to 23
    // R11: these inputs stay active low
    for (int k = 0; k < 4; k++) begin
      src[IRQ_LINE_A + k] = internal_irq[IRQ_LINE_A + k]
                            && !(advanced_mode && line_on[k]);
      src[IRQ_LINE_E + k] = internal_irq[IRQ_LINE_E + k]
                            && !(advanced_mode && !shared_lines_e_to_h_request_b[k]);
    end
  end

  // ****************************************
  // Input cells
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N_IRQ; g++) begin : g_cell
      iar_irq_cell u_cell (
        .clk        (clk),
        .rst_b      (rst_b),
        .raw        (src[g]),
        .active_low (r_ff.pol[g]),
        .level      (r_ff.lvl[g]),
        .mask       (r_ff.msk[g]),
        .sent       (sent[g]),
        .eoi_hit    (eoi_hit[g]),
        .req        (req[g])
      );
    end
  endgenerate

  // ****************************************
  // Arbitration
  // ****************************************
  always_comb begin
    win_any = 1'b0;
    win_idx = '0;
    win_prio = '0;
    // R02: highest programmed priority wins, ties to lower index
    for (int i = 0; i < N_IRQ; i++) begin
      if (req[i] && (!win_any || r_ff.prio[i] > win_prio)) begin
        win_any = 1'b1;
        win_idx = IDX_W'(i);
        win_prio = r_ff.prio[i];
      end
    end
  end

  // ****************************************
  // Delivery feedback
  // ****************************************
  // Write taken by the sink this cycle
  assign accept = (r_ff.st == IAR_SEND) && wr_ready;

  // Any pending request, sending flag and last chosen input
  assign stat_word = {7'h00, win_any, r_ff.st == IAR_SEND, r_ff.idx};

  always_comb begin
    sent = '0;
    eoi_hit = '0;
    for (int i = 0; i < N_IRQ; i++) begin
      sent[i] = accept && (r_ff.idx == IDX_W'(i));
      eoi_hit[i] = eoi_valid && (r_ff.vec[i] == eoi_vector);
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    // Line A pin, three stages, counts when stages two and three agree
    nxt_r.pin_s1 = shared_line_a_request_b;
    nxt_r.pin_s2 = r_ff.pin_s1;
    nxt_r.pin_s3 = r_ff.pin_s2;
    if (r_ff.pin_s2 == r_ff.pin_s3) begin
      nxt_r.pin_lvl = r_ff.pin_s3;
    end
    // R13: message assert and deassert
    if (intx_msg_valid) begin
      nxt_r.intx[intx_msg_line] = intx_msg_assert;
    end
    // R03: per-input settings
    // R19: vector, trigger, polarity held
    // Indexes past the last input are dropped
    if (ent_wr && (ent_idx < IDX_W'(N_IRQ))) begin
      nxt_r.vec[ent_idx] = ent_vector;
      nxt_r.prio[ent_idx] = ent_prio;
      nxt_r.lvl[ent_idx] = ent_level;
      nxt_r.pol[ent_idx] = ent_active_low;
      nxt_r.msk[ent_idx] = ent_mask;
    end
    // R14: identity field
    // R15: identity only feeds the message
    if (cfg_wr && cfg_addr == OFS_RID) begin
      nxt_r.rid = cfg_wdata;
    end
    if (cfg_rd) begin
      case (cfg_addr)
        OFS_RID:  nxt_r.rdata = r_ff.rid;
        OFS_STAT: nxt_r.rdata = stat_word;
        default:  nxt_r.rdata = '0;
      endcase
    end
    // R01: delivery as a posted write
    case (r_ff.st)
      IAR_IDLE: begin
        if (win_any) begin
          nxt_r.st = IAR_SEND;
          nxt_r.idx = win_idx;
          // R03: vector of the winner
          nxt_r.out_vec = r_ff.vec[win_idx];
          // R14: requester identity stamped
          nxt_r.out_rid = r_ff.rid;
        end
      end
      IAR_SEND: begin
        // Vector and identity stay put until the sink takes the write
        if (wr_ready) begin
          nxt_r.st = IAR_IDLE;
        end
      end
      default: begin
        nxt_r.st = IAR_IDLE;
      end
    endcase
    // R16: end-of-interrupt to Express only
    // R17: external controllers behind Express
    nxt_r.fwd = eoi_valid;
    if (eoi_valid) begin
      nxt_r.fwd_vec = eoi_vector;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff.vec     <= {N_IRQ{VEC_RST}};
      r_ff.prio    <= {N_IRQ{PRIO_RST}};
      r_ff.lvl     <= LVL_RST;
      r_ff.pol     <= POL_RST;
      r_ff.msk     <= MSK_RST;
      r_ff.rid     <= RID_RST;
      r_ff.intx    <= 4'h0;
      r_ff.pin_s1  <= 1'b1;
      r_ff.pin_s2  <= 1'b1;
      r_ff.pin_s3  <= 1'b1;
      r_ff.pin_lvl <= 1'b1;
      r_ff.st      <= IAR_IDLE;
      r_ff.idx     <= '0;
      r_ff.out_vec <= '0;
      r_ff.out_rid <= '0;
      r_ff.fwd     <= 1'b0;
      r_ff.fwd_vec <= '0;
      r_ff.rdata   <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wr_valid        = (r_ff.st == IAR_SEND);
  assign wr_vector       = r_ff.out_vec;
  assign wr_requester_id = r_ff.out_rid;
  assign eoi_pcie_fwd    = r_ff.fwd;
  assign eoi_pcie_vector = r_ff.fwd_vec;
  assign cfg_rdata       = r_ff.rdata;

endmodule // iar_router

// ==== common/iar_pkg.sv ====
/*
 * Constants, reset values and state codes of the interrupt router.
 * Assumes a single 40 MHz clock domain and active-low async reset.
 */
//
// Summary of operation
// R01: Every interrupt leaves as one memory write; no acknowledge cycle exists.
// R02: Arbitration uses the programmed priority, never the input number; the code breaks equal priorities by lower input number.
// R03: Each input owns a software vector carried in its message.
// R04: Input 0 takes only the cascade output of the legacy controller.
// R05: Input 2 takes interval timer counter 0 or event timer 0 legacy.
// R06: Input 8 takes the real-time clock or event timer 1 legacy.
// R07: Input 16 takes line A from stream, pin, message or internal source.
// R08: Software gives inputs 24 to 119 at most one source each.
// R09: Inputs 24 to 119 still select level or edge triggering.
// R10: In advanced mode shared lines A to H drive inputs 16 to 23.
// R11: Inputs 16 to 23 are active low, all others active high.
// R12: Software keeps stream interrupts off inputs used by shared lines.
// R13: Express assert and deassert messages drive shared lines A to D.
// R14: Each message carries the programmable requester identity.
// R15: The identity field changes no behaviour; no separate function.
// R16: End-of-interrupt is forwarded to Express ports only.
// R17: External controllers are served only behind Express ports.
// R18: Software sets shared lines routed to legacy inputs level sensitive.
// R19: Per input vector, trigger and polarity; resend on edge or held level.
package iar_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned N_IRQ   = 120;
  localparam int unsigned VEC_W   = 8;
  localparam int unsigned PRIO_W  = 4;
  localparam int unsigned IDX_W   = 7;
  localparam int unsigned RID_W   = 16;

  // ****************************************
  // Input positions
  // ****************************************
  localparam int unsigned IRQ_CASCADE = 0;
  localparam int unsigned IRQ_TIMER   = 2;
  localparam int unsigned IRQ_RTC     = 8;
  localparam int unsigned IRQ_RSVD    = 13;
  localparam int unsigned IRQ_LINE_A  = 16;
  localparam int unsigned IRQ_LINE_E  = 20;
  localparam int unsigned IRQ_DEDIC   = 24;
  localparam int unsigned N_LEGACY    = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_RID  = 8'h6C;
  localparam logic [7:0] OFS_STAT = 8'h70;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [RID_W-1:0]  RID_RST  = 16'h0000;
  localparam logic [VEC_W-1:0]  VEC_RST  = 8'h00;
  localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
  localparam logic [N_IRQ-1:0]  POL_RST  = 120'h0000_0000_0000_0000_0000_0000_FF_0000;
  localparam logic [N_IRQ-1:0]  MSK_RST  = {N_IRQ{1'b1}};
  localparam logic [N_IRQ-1:0]  LVL_RST  = {N_IRQ{1'b0}};

  // ****************************************
  // Delivery states
  // ****************************************
  typedef enum logic [0:0] {
    IAR_IDLE = 1'b0,
    IAR_SEND = 1'b1
  } iar_state_t;

endpackage

// ==== core/iar_irq_cell.sv ====
/*
 * One interrupt input: polarity, trigger detection, pending and
 * remote-pending state. Inputs are already on the core clock.
 */
`timescale 1ns/1ps
module iar_irq_cell
  import iar_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Source and settings
  input  wire logic raw,
  input  wire logic active_low,
  input  wire logic level,
  input  wire logic mask,
  // Delivery feedback
  input  wire logic sent,
  input  wire logic eoi_hit,
  // Request to the arbiter
  output logic      req
);

  typedef struct packed {
    logic prev;
    logic pend;
    logic rirr;
  } iar_cell_t;

  iar_cell_t st_ff;
  iar_cell_t nxt_st;
  logic      act;

  always_comb begin
    nxt_st = st_ff;
    act = raw ^ active_low;
    nxt_st.prev = act;
    // R19: edge latch
    if (level) begin
      nxt_st.pend = 1'b0;
    end else if (act && !st_ff.prev && !mask) begin
      nxt_st.pend = 1'b1;
    end else if (sent) begin
      nxt_st.pend = 1'b0;
    end
    // R19: held level resends after end-of-interrupt
    if (!level) begin
      nxt_st.rirr = 1'b0;
    end else if (sent) begin
      nxt_st.rirr = 1'b1;
    end else if (eoi_hit) begin
      nxt_st.rirr = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // R09: both triggers on every input
  assign req = level ? (act && !mask && !st_ff.rirr) : st_ff.pend;

endmodule // iar_irq_cell

// ==== dv/iar_sink.sv ====
/* Write sink standing for the processor side of the router.
 * Assumes the router clock; stall sets the wait before each accept. */
`timescale 1ns/1ps
module iar_sink
  import iar_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Interrupt write
  input  wire logic             wr_valid,
  input  wire logic [VEC_W-1:0] wr_vector,
  input  wire logic [RID_W-1:0] wr_requester_id,
  output logic                  wr_ready,
  // Control and record
  input  wire logic [3:0]       stall,
  output int                    got,
  output logic      [VEC_W-1:0] last_vec,
  output logic      [RID_W-1:0] last_rid
);
  logic [3:0] wt_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ready <= 1'b0;
      wt_ff    <= 4'h0;
      got      <= 0;
    end else begin
      wr_ready <= 1'b0;
      if (wr_valid && wr_ready) begin
        got      <= got + 1;
        last_vec <= wr_vector;
        last_rid <= wr_requester_id;
      end else if (wr_valid) begin
        wt_ff    <= (wt_ff >= stall) ? 4'h0 : wt_ff + 4'h1;
        wr_ready <= (wt_ff >= stall);
      end
    end
  end
endmodule // iar_sink

// ==== dv/iar_router_properties.sv ====
/* Port assertions of the interrupt router.
 * Assumes one clock domain; bound to every router instance. */
`timescale 1ns/1ps
module iar_router_properties
  import iar_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Configuration
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [RID_W-1:0] cfg_wdata,
  input  wire logic [RID_W-1:0] cfg_rdata,
  // Write and end of interrupt
  input  wire logic             wr_valid,
  input  wire logic             wr_ready,
  input  wire logic [VEC_W-1:0] wr_vector,
  input  wire logic [RID_W-1:0] wr_requester_id,
  input  wire logic             eoi_valid,
  input  wire logic [VEC_W-1:0] eoi_vector,
  input  wire logic             eoi_pcie_fwd,
  input  wire logic [VEC_W-1:0] eoi_pcie_vector
);
  logic [RID_W-1:0] rid_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rid_ff <= RID_RST;
    else if (cfg_wr && cfg_addr == OFS_RID) rid_ff <= cfg_wdata;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_valid_hold: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable(wr_vector) && $stable(wr_requester_id)) else $error("write not held");
  chk_accept_gap: assert property (wr_valid && wr_ready |=> !wr_valid)
    else $error("no gap after write");
  chk_eoi_fwd: assert property (eoi_valid |=>
    eoi_pcie_fwd && eoi_pcie_vector == $past(eoi_vector)) else $error("eoi not forwarded");
  chk_eoi_only: assert property (eoi_pcie_fwd |-> $past(eoi_valid))
    else $error("spurious eoi forward");
  chk_rid_msg: assert property ($rose(wr_valid) && !$past(cfg_wr) |->
    wr_requester_id == rid_ff) else $error("wrong requester id");
  chk_rid_read: assert property (cfg_rd && !cfg_wr && cfg_addr == OFS_RID |=>
    cfg_rdata == rid_ff) else $error("id read wrong");
  chk_unmapped_zero: assert property (cfg_rd && cfg_addr != OFS_RID &&
    cfg_addr != OFS_STAT |=> cfg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
    else $error("read data moved");

  cover property (wr_valid && wr_ready);
  cover property (wr_valid && !wr_ready);
  cover property (eoi_pcie_fwd);
endmodule // iar_router_properties

bind iar_router iar_router_properties iar_router_properties_i (
  .clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_vector(wr_vector), .wr_requester_id(wr_requester_id), .eoi_valid(eoi_valid),
  .eoi_vector(eoi_vector), .eoi_pcie_fwd(eoi_pcie_fwd), .eoi_pcie_vector(eoi_pcie_vector)
);

// ==== dv/iar_router_tb.sv ====
/* Self-checking bench of the interrupt router.
 * Assumes the write sink model and the bound port checker. */
`timescale 1ns/1ps
module iar_router_tb;
  import iar_pkg::*;
  logic clk, rst_b, advanced_mode, high_precision_event_timer_legacy_en, legacy_cascade;
  logic timer_counter0, high_precision_event_timer_0, rtc_irq, high_precision_event_timer_1;
  logic shared_line_a_request_b;
  logic intx_msg_valid, intx_msg_assert, ent_wr, ent_level, ent_active_low, ent_mask;
  logic cfg_wr, cfg_rd, wr_valid, wr_ready, eoi_valid, eoi_pcie_fwd;
  logic [N_LEGACY-1:0] serial_interrupt_stream_irq;
  logic [3:0] serial_interrupt_stream_line_b, shared_lines_e_to_h_request_b, stall;
  logic [1:0] intx_msg_line;
  logic [N_IRQ-1:0] internal_irq;
  logic [IDX_W-1:0] ent_idx;
  logic [VEC_W-1:0] ent_vector, wr_vector, eoi_vector, eoi_pcie_vector, last_vec;
  logic [PRIO_W-1:0] ent_prio;
  logic [7:0] cfg_addr;
  logic [RID_W-1:0] cfg_wdata, cfg_rdata, wr_requester_id, last_rid, rid;
  int error_cnt, checked, got, seen;

  iar_router iar_router_i (
    .clk(clk), .rst_b(rst_b), .advanced_mode(advanced_mode),
    .high_precision_event_timer_legacy_en(high_precision_event_timer_legacy_en),
    .legacy_cascade(legacy_cascade), .timer_counter0(timer_counter0),
    .high_precision_event_timer_0(high_precision_event_timer_0), .rtc_irq(rtc_irq),
    .high_precision_event_timer_1(high_precision_event_timer_1),
    .serial_interrupt_stream_irq(serial_interrupt_stream_irq),
    .serial_interrupt_stream_line_b(serial_interrupt_stream_line_b),
    .shared_line_a_request_b(shared_line_a_request_b),
    .shared_lines_e_to_h_request_b(shared_lines_e_to_h_request_b),
    .intx_msg_valid(intx_msg_valid), .intx_msg_assert(intx_msg_assert),
    .intx_msg_line(intx_msg_line), .internal_irq(internal_irq),
    .ent_wr(ent_wr), .ent_idx(ent_idx), .ent_vector(ent_vector), .ent_prio(ent_prio),
    .ent_level(ent_level), .ent_active_low(ent_active_low), .ent_mask(ent_mask),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_vector(wr_vector),
    .wr_requester_id(wr_requester_id), .eoi_valid(eoi_valid), .eoi_vector(eoi_vector),
    .eoi_pcie_fwd(eoi_pcie_fwd), .eoi_pcie_vector(eoi_pcie_vector)
  );
  iar_sink iar_sink_i (
    .clk(clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr_vector(wr_vector),
    .wr_requester_id(wr_requester_id), .wr_ready(wr_ready), .stall(stall), .got(got),
    .last_vec(last_vec), .last_rid(last_rid)
  );

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, a, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cfg(input logic w, input logic [7:0] a, input logic [15:0] d);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 0;
    cfg_rd = 0;
    cyc(1);
    if (!w) cmp(cfg_rdata, d);
  endtask

  task automatic prog(input int i, input logic [7:0] v, input logic [3:0] p, input logic l);
    ent_wr = 1;
    ent_idx = i[6:0];
    ent_vector = v;
    ent_prio = p;
    ent_level = l;
    ent_active_low = (i >= 16 && i < 24);
    ent_mask = 0;
    cyc(1);
    ent_wr = 0;
    cyc(1);
  endtask

  task automatic msg(input logic [7:0] v);
    int k;
    k = 0;
    while (got == seen && k < 60) begin
      cyc(1);
      k++;
    end
    if (got == seen) begin
      error_cnt++;
      close_out();
    end
    seen++;
    cmp(last_vec, v);
    cmp(last_rid, rid);
  endtask

  task automatic quiet(input int n);
    cyc(n);
    cmp(got, seen);
  endtask

  task automatic eoi(input logic [7:0] v);
    eoi_valid = 1;
    eoi_vector = v;
    cyc(1);
    eoi_valid = 0;
    cmp(eoi_pcie_fwd, 1);
    cmp(eoi_pcie_vector, v);
  endtask

  task automatic s_regs();
    cfg(0, OFS_RID, RID_RST);
    cfg(0, OFS_STAT, 16'h0000);
    cfg(1, OFS_RID, rid);
    cfg(0, OFS_RID, rid);
    cfg(1, 8'h40, 16'hFFFF);
    cfg(0, 8'h40, 16'h0000);
    cfg(0, OFS_RID, rid);
  endtask

  task automatic s_fixed();
    for (int k = 0; k < 5; k++) begin
      prog(k == 0 ? 0 : (k < 3 ? 2 : 8), 8'h20 + k, 4'h1, 0);
      high_precision_event_timer_legacy_en = (k == 2 || k == 4);
      {high_precision_event_timer_1, rtc_irq, high_precision_event_timer_0, timer_counter0,
       legacy_cascade} = 5'h01 << k;
      msg(8'h20 + k);
      {high_precision_event_timer_1, rtc_irq, high_precision_event_timer_0, timer_counter0,
       legacy_cascade} = 5'h00;
      cyc(2);
    end
    serial_interrupt_stream_irq = 16'h0105;
    quiet(10);
    serial_interrupt_stream_irq = 16'h0000;
  endtask

  task automatic s_prio();
    stall = 4'h6;
    prog(3, 8'h33, 4'h1, 0);
    prog(10, 8'h3A, 4'h9, 0);
    serial_interrupt_stream_irq = 16'h0408;
    msg(8'h3A);
    msg(8'h33);
    cfg(0, OFS_STAT, 16'h0003);
    serial_interrupt_stream_irq = 16'h0000;
    stall = 4'h0;
  endtask

  task automatic s_level();
    prog(30, 8'h5E, 4'h2, 1);
    internal_irq[30] = 1;
    msg(8'h5E);
    quiet(10);
    eoi(8'h5E);
    msg(8'h5E);
    internal_irq[30] = 0;
    eoi(8'h5E);
    quiet(10);
  endtask

  task automatic s_lines();
    prog(20, 8'h64, 4'h3, 0);
    shared_lines_e_to_h_request_b = 4'hE;
    quiet(10);
    advanced_mode = 1;
    msg(8'h64);
    prog(17, 8'h61, 4'h3, 1);
    intx_msg_valid = 1;
    intx_msg_assert = 1;
    intx_msg_line = 2'd1;
    cyc(1);
    intx_msg_valid = 0;
    msg(8'h61);
    intx_msg_valid = 1;
    intx_msg_assert = 0;
    cyc(1);
    intx_msg_valid = 0;
    eoi(8'h61);
    quiet(10);
    prog(16, 8'h60, 4'h3, 0);
    shared_line_a_request_b = 0;
    msg(8'h60);
    prog(23, 8'h67, 4'h3, 0);
    internal_irq[23] = 0;
    msg(8'h67);
  endtask

  initial begin
    rst_b = 0;
    {advanced_mode, high_precision_event_timer_legacy_en, legacy_cascade, timer_counter0} = '0;
    {high_precision_event_timer_0, rtc_irq, high_precision_event_timer_1} = '0;
    {intx_msg_valid, intx_msg_assert, intx_msg_line} = '0;
    {ent_wr, ent_idx, ent_vector, ent_prio, ent_level, ent_active_low, ent_mask} = 0;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, eoi_valid, eoi_vector} = 0;
    {shared_line_a_request_b, shared_lines_e_to_h_request_b} = 5'h1F;
    serial_interrupt_stream_line_b = 4'hF;
    serial_interrupt_stream_irq = 16'h0000;
    internal_irq = 0;
    internal_irq[23:16] = 8'hFF;
    stall = 4'h0;
    rid = 16'hA5C3;
    cyc(2);
    rst_b = 1;
    cyc(1);
    s_regs();
    s_fixed();
    s_prio();
    s_level();
    s_lines();
    close_out();
  end
endmodule // iar_router_tb
